// file: src/autoneg_defines.vh
`ifndef AUTONEG_DEFINES_VH
`define AUTONEG_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_CTRL         6'h00
`define IDX_STATUS       6'h01
`define IDX_ADVERTISE    6'h04
`define IDX_PARTNER      6'h05

// Control register fields
`define CTRL_SOFT_RESET  15
`define CTRL_SPEED_LO    13
`define CTRL_AN_ENABLE   12
`define CTRL_POWER_DOWN  11
`define CTRL_AN_RESTART  9
`define CTRL_DUPLEX      8
`define CTRL_SPEED_HI    6
`define CTRL_POWER_ALT   2
`define CTRL_RW_MASK     16'h3944
`define CTRL_RESET       16'h1140

// Advertisement register fields
`define ADV_ABIL_HI      7
`define ADV_ABIL_LO      5
`define ADV_SEL_HI       4
`define ADV_SEL_LO       0
`define ADV_ABIL_RESET   3'h7
`define ADV_SEL_RESET    5'h01

// Partner ability register reset
`define PARTNER_RESET    16'h0000

// Status register fields
`define STAT_LINK_UP     8
`define STAT_AN_ACTIVE   9
`define STAT_GIG_FULL    10
`define STAT_GIG_HALF    11

// Forced speed code {hi,lo} meaning 1000 Mbps
`define SPEED_1000       2'h2

// Bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// file: src/level_sync.v
`timescale 1ns/1ps

module level_sync #(
	parameter WIDTH = 1
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] asyncIn,
	output reg  [WIDTH-1:0] syncOut
);

	reg [WIDTH-1:0] stage1;

	// First stage feeds only the second
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1  <= {WIDTH{1'b0}};
			syncOut <= {WIDTH{1'b0}};
		end else begin
			stage1  <= asyncIn;
			syncOut <= stage1;
		end
	end

endmodule

// file: src/autoneg_ability_registers.v
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "autoneg_defines.vh"

module autoneg_ability_registers #(
	parameter ADDR_WIDTH = 8
) (
	input  wire                  clk,
	input  wire                  rst_n,
	// AXI4-Lite slave
	input  wire [ADDR_WIDTH-1:0] s_axi_awaddr,
	input  wire [2:0]            s_axi_awprot,
	input  wire                  s_axi_awvalid,
	output reg                   s_axi_awready,
	input  wire [31:0]           s_axi_wdata,
	input  wire [3:0]            s_axi_wstrb,
	input  wire                  s_axi_wvalid,
	output reg                   s_axi_wready,
	output reg  [1:0]            s_axi_bresp,
	output reg                   s_axi_bvalid,
	input  wire                  s_axi_bready,
	input  wire [ADDR_WIDTH-1:0] s_axi_araddr,
	input  wire [2:0]            s_axi_arprot,
	input  wire                  s_axi_arvalid,
	output reg                   s_axi_arready,
	output reg  [31:0]           s_axi_rdata,
	output reg  [1:0]            s_axi_rresp,
	output reg                   s_axi_rvalid,
	input  wire                  s_axi_rready,
	// Negotiation receiver, same clock
	input  wire                  rxPageValid,
	input  wire [15:0]           rxCodeWord,
	// Gigabit advertisement from the gigabit control logic
	input  wire                  gigAdvFull,
	input  wire                  gigAdvHalf,
	// Copper link status pin, asynchronous
	input  wire                  linkUpPin,
	// Toward the negotiation state machine
	output reg  [7:0]            advAbility,
	output reg                   adv1000Full,
	output reg                   adv1000Half,
	output reg                   anActive,
	output reg                   anRestart
);

	////////////////////////////////////////////////////////////////////////
	// Storage

	reg  [15:0] ctrl;
	reg  [2:0]  pendAbil;
	reg  [4:0]  selector;
	reg  [2:0]  effAbil;
	reg  [15:0] partner;
	reg         powerPrev;
	reg         linkPrev;
	wire        linkSync;

	level_sync #(
		.WIDTH   (1)
	) u_link_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn (linkUpPin),
		.syncOut (linkSync)
	);

	////////////////////////////////////////////////////////////////////////
	// Write channel capture

	reg  [ADDR_WIDTH-1:0] wrAddr;
	reg  [15:0]           wrData;
	reg  [1:0]            wrStrb;
	reg                   awHeld;
	reg                   wHeld;
	wire                  awTake;
	wire                  wTake;
	wire                  wrFire;
	wire [5:0]            wrIdx;
	wire                  wrAligned;

	assign awTake    = s_axi_awvalid & s_axi_awready;
	assign wTake     = s_axi_wvalid & s_axi_wready;
	assign wrFire    = awHeld & wHeld & ~s_axi_bvalid;
	assign wrIdx     = wrAddr[7:2];
	// Shift, not slice: an empty upper range must still elaborate at 8 bits
	assign wrAligned = (wrAddr[1:0] == 2'h0) &&
		((wrAddr >> 8) == {ADDR_WIDTH{1'b0}});

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrAddr <= {ADDR_WIDTH{1'b0}};
			wrData <= 16'h0000;
			wrStrb <= 2'h0;
			awHeld <= 1'b0;
			wHeld  <= 1'b0;
		end else begin
			if (awTake) begin
				wrAddr <= s_axi_awaddr;
				awHeld <= 1'b1;
			end else if (wrFire) begin
				awHeld <= 1'b0;
			end
			if (wTake) begin
				wrData <= s_axi_wdata[15:0];
				wrStrb <= s_axi_wstrb[1:0];
				wHeld  <= 1'b1;
			end else if (wrFire) begin
				wHeld  <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write decode

	reg wrCtrl;
	reg wrAdv;
	reg wrMapped;

	always @* begin
		wrCtrl   = 1'b0;
		wrAdv    = 1'b0;
		wrMapped = 1'b0;
		if (!wrFire || !wrAligned) begin
			wrMapped = 1'b0;
		end else if (wrIdx == `IDX_CTRL) begin
			wrCtrl   = 1'b1;
			wrMapped = 1'b1;
		end else if (wrIdx == `IDX_ADVERTISE) begin
			wrAdv    = 1'b1;
			wrMapped = 1'b1;
		end else if (wrIdx == `IDX_STATUS || wrIdx == `IDX_PARTNER) begin
			// Read-only registers take the write and drop it
			wrMapped = 1'b1;
		end
	end

	// Byte-lane merge for the control register
	wire [15:0] laneMask;
	wire [15:0] ctrlMerged;

	assign laneMask   = {{8{wrStrb[1]}}, {8{wrStrb[0]}}};
	assign ctrlMerged = (ctrl & ~laneMask) | (wrData & laneMask);

	////////////////////////////////////////////////////////////////////////
	// Update events

	wire softReset;
	wire restartReq;
	wire powerNow;
	wire powerUp;
	wire linkDrop;
	wire applyPend;

	// Self-clearing command bits act in the cycle of the write
	assign softReset  = wrCtrl & wrStrb[1] & wrData[`CTRL_SOFT_RESET];
	assign restartReq = wrCtrl & wrStrb[1] & wrData[`CTRL_AN_RESTART];
	assign powerNow   = ctrl[`CTRL_POWER_DOWN] | ctrl[`CTRL_POWER_ALT];
	assign powerUp    = powerPrev & ~powerNow;
	assign linkDrop   = linkPrev & ~linkSync;
	assign applyPend  = softReset | restartReq | powerUp | linkDrop;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			powerPrev <= 1'b0;
			linkPrev  <= 1'b0;
		end else begin
			powerPrev <= powerNow;
			linkPrev  <= linkSync;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= `CTRL_RESET;
		end else if (wrCtrl) begin
			// Command bits never stored, so they read back as zero
			ctrl <= ctrlMerged & `CTRL_RW_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Advertisement register

	reg [2:0] next_pendAbil;
	reg [4:0] next_selector;

	always @* begin
		next_pendAbil = pendAbil;
		next_selector = selector;
		if (wrAdv && wrStrb[0]) begin
			next_pendAbil = wrData[`ADV_ABIL_HI:`ADV_ABIL_LO];
			next_selector = wrData[`ADV_SEL_HI:`ADV_SEL_LO];
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pendAbil <= `ADV_ABIL_RESET;
			selector <= `ADV_SEL_RESET;
			effAbil  <= `ADV_ABIL_RESET;
		end else begin
			pendAbil <= next_pendAbil;
			// Soft reset leaves the selector alone
			selector <= next_selector;
			// Uses the incoming value, so a write landing with a link
			// drop is not lost
			if (applyPend) begin
				effAbil <= next_pendAbil;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Partner base page

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			partner <= `PARTNER_RESET;
		end else if (softReset) begin
			partner <= `PARTNER_RESET;
		end else if (rxPageValid) begin
			// Whole code word at once; no bit is software-writable
			partner <= rxCodeWord;
		end
	end
	// Bits 12..0 likewise straight copies
	// Ability bits and selector

	////////////////////////////////////////////////////////////////////////
	// Negotiation outputs

	wire forced1000;

	assign forced1000 = ~ctrl[`CTRL_AN_ENABLE] &
		({ctrl[`CTRL_SPEED_HI], ctrl[`CTRL_SPEED_LO]} == `SPEED_1000);

	// Gigabit needs negotiation, so forcing it still negotiates; software
	// is expected not to rely on plain forced gigabit
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			advAbility  <= {`ADV_ABIL_RESET, `ADV_SEL_RESET};
			adv1000Full <= 1'b0;
			adv1000Half <= 1'b0;
			anActive    <= 1'b1;
			anRestart   <= 1'b0;
		end else begin
			anActive  <= ctrl[`CTRL_AN_ENABLE] | forced1000;
			anRestart <= softReset | restartReq;
			if (forced1000) begin
				advAbility  <= {3'h0, selector};
				adv1000Full <= ctrl[`CTRL_DUPLEX];
				adv1000Half <= ~ctrl[`CTRL_DUPLEX];
			end else begin
				advAbility  <= {effAbil, selector};
				adv1000Full <= gigAdvFull;
				adv1000Half <= gigAdvHalf;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write response and ready

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			if (awTake) begin
				s_axi_awready <= 1'b0;
			end
			if (wTake) begin
				s_axi_wready <= 1'b0;
			end
			if (wrFire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				// Next write only after the answer is taken
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path

	wire [5:0] rdIdx;
	wire       rdAligned;
	wire       arTake;
	reg [15:0] rdWord;
	reg        rdMapped;

	assign arTake    = s_axi_arvalid & s_axi_arready;
	assign rdIdx     = s_axi_araddr[7:2];
	assign rdAligned = (s_axi_araddr[1:0] == 2'h0) &&
		((s_axi_araddr >> 8) == {ADDR_WIDTH{1'b0}});

	always @* begin
		rdWord   = 16'h0000;
		rdMapped = 1'b1;
		if (!rdAligned) begin
			rdMapped = 1'b0;
		end else if (rdIdx == `IDX_CTRL) begin
			rdWord = ctrl;
		end else if (rdIdx == `IDX_STATUS) begin
			rdWord[7:0]             = advAbility;
			rdWord[`STAT_LINK_UP]   = linkSync;
			rdWord[`STAT_AN_ACTIVE] = anActive;
			rdWord[`STAT_GIG_FULL]  = adv1000Full;
			rdWord[`STAT_GIG_HALF]  = adv1000Half;
		end else if (rdIdx == `IDX_ADVERTISE) begin
			// Software sees what it wrote, effective or not
			rdWord[`ADV_ABIL_HI:`ADV_ABIL_LO] = pendAbil;
			rdWord[`ADV_SEL_HI:`ADV_SEL_LO]   = selector;
		end else if (rdIdx == `IDX_PARTNER) begin
			rdWord = partner;
		end else begin
			rdMapped = 1'b0;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (arTake) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {16'h0000, rdWord};
			s_axi_rresp   <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

// file: test/autoneg_ability_registers_assertions.sv
`timescale 1ns/1ps
`include "autoneg_defines.vh"
module autoneg_ability_checker (
	input wire        clk,
	input wire        rst_n,
	input wire        s_axi_awready,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire [7:0]  advAbility,
	input wire        anRestart,
	input wire        rxPageValid
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("response moved");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	aw_block_a: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready) else $error("write taken while busy");
	restart_pulse_a: assert property (anRestart |=> !anRestart)
		else $error("restart longer than one cycle");
	rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 0)
		else $error("upper read bits set");
	// Selector is not staged, so it may only move on a write
	sel_write_a: assert property ($changed(advAbility[4:0]) |->
		s_axi_bvalid || $past(s_axi_bvalid)) else $error("selector moved");
	resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp ==
		`RESP_OKAY || s_axi_bresp == `RESP_SLVERR) else $error("bad resp");
	// Restart only comes from a control write, launched with its answer
	restart_src_a: assert property (anRestart |-> s_axi_bvalid)
		else $error("restart without a write");
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (anRestart);
	cover property (rxPageValid);
endmodule
bind autoneg_ability_registers autoneg_ability_checker checker_i (.clk,
	.rst_n, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .advAbility, .anRestart, .rxPageValid);

// file: test/link_partner_model.sv
`timescale 1ns/1ps
module link_partner_model (
	input  wire        clk,
	input  wire        send,
	input  wire [15:0] word,
	input  wire        linkReq,
	output reg         rxPageValid,
	output reg  [15:0] rxCodeWord,
	output reg         linkUpPin
);
	initial begin
		rxPageValid = 1'b0;
		rxCodeWord = 16'h0000;
		linkUpPin = 1'b1;
	end
	always @(posedge clk) begin
		rxPageValid <= send;
		// Off the strobe the word flips so a stale copy cannot pass
		rxCodeWord <= send ? word : ~rxCodeWord;
		linkUpPin <= linkReq;
	end
endmodule

// file: test/test_autoneg_ability_registers.sv
`timescale 1ns/1ps
`include "autoneg_defines.vh"
module test_autoneg_ability_registers;
	logic        clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, gigAdvFull, gigAdvHalf;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, adv1000Full, adv1000Half, anActive, anRestart;
	logic        rxPageValid, linkUpPin, send, linkReq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, advAbility;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [2:0]  s_axi_awprot, s_axi_arprot, pend, eff;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [15:0] rxCodeWord, word, rd, part;
	logic [4:0]  sel;
	logic [15:0] pageQ[$];
	integer      mismatches, comparisons, seed, i;
	autoneg_ability_registers dut (.clk, .rst_n, .s_axi_awaddr,
		.s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .rxPageValid, .rxCodeWord,
		.gigAdvFull, .gigAdvHalf, .linkUpPin, .advAbility, .adv1000Full,
		.adv1000Half, .anActive, .anRestart);
	link_partner_model partner (.clk, .send, .word, .linkReq,
		.rxPageValid, .rxCodeWord, .linkUpPin);
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	////////////////////////////////////////
	task automatic chk(input [15:0] got, input [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input [7:0] a, input [15:0] d, input [3:0] s);
		bit da, dw;
		da = 0;
		dw = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= s;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		while (!(da && dw)) begin
			@(posedge clk);
			if (s_axi_awready) begin
				da = 1;
				s_axi_awvalid <= 0;
			end
			if (s_axi_wready) begin
				dw = 1;
				s_axi_wvalid <= 0;
			end
		end
		do @(posedge clk); while (!s_axi_bvalid);
		s_axi_bready <= 0;
		resp = s_axi_bresp;
	endtask
	task automatic rdreg(input [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge clk); while (!s_axi_rvalid);
		s_axi_rready <= 0;
		rd = s_axi_rdata[15:0];
		resp = s_axi_rresp;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (6000) @(posedge clk);
		mismatches++;
		complete_run;
	end
	initial begin
		{mismatches, comparisons, seed} = {32'h0, 32'h0, 32'h1A};
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
		{s_axi_arvalid, s_axi_rready, send, word} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 0;
		{s_axi_awprot, s_axi_arprot, linkReq} = 7'h01;
		{gigAdvFull, gigAdvHalf} = 2'($random(seed));
		{pend, eff, sel} = 11'h7E1;
		repeat (10) @(posedge clk);
		rst_n <= 1;
		rdreg(8'h10);
		chk(rd, 16'h00E1);
		chk({8'h00, advAbility}, 16'h00E1);
		rdreg(8'h14);
		chk(rd, 16'h0000);
		for (i = 0; i < 5; i++) begin
			word <= (i == 0) ? 16'hFFFF : 16'($random(seed));
			send <= 1;
			@(posedge clk);
			pageQ.push_back(word);
			send <= 0;
			repeat (2) @(posedge clk);
			part = pageQ.pop_front();
			rdreg(8'h14);
			chk(rd, part);
		end
		wr(8'h14, ~part, 4'h3);
		chk(16'(resp), 16'(`RESP_OKAY));
		rdreg(8'h14);
		chk(rd, part);
		// One pass per apply event: restart, power-up, link loss, soft reset
		for (i = 0; i < 4; i++) begin
			pend = 3'($random(seed));
			sel = 5'($random(seed));
			wr(8'h10, {8'h00, pend, sel}, 4'h1);
			rdreg(8'h10);
			chk(rd, {8'h00, pend, sel});
			chk({8'h00, advAbility}, {8'h00, eff, sel});
			if (i == 0)
				wr(8'h00, 16'h1340, 4'h3);
			if (i == 1) begin
				wr(8'h00, 16'h1940, 4'h3);
				wr(8'h00, 16'h1140, 4'h3);
			end
			if (i == 2) begin
				linkReq <= 0;
				repeat (8) @(posedge clk);
				linkReq <= 1;
			end
			if (i == 3)
				wr(8'h00, 16'h9140, 4'h3);
			repeat (8) @(posedge clk);
			eff = pend;
			chk({8'h00, advAbility}, {8'h00, eff, sel});
		end
		rdreg(8'h14);
		chk(rd, 16'h0000);
		{gigAdvFull, gigAdvHalf} <= 2'h3;
		wr(8'h00, 16'h0140, 4'h3);
		repeat (4) @(posedge clk);
		chk(16'({anActive, adv1000Full, adv1000Half, advAbility[7:5]}),
			16'h0030);
		rdreg(8'h04);
		chk(rd, {8'h07, 3'h0, sel});
		wr(8'h00, 16'h0040, 4'h3);
		repeat (4) @(posedge clk);
		chk(16'({anActive, adv1000Full, adv1000Half, advAbility[7:5]}),
			16'h0028);
		wr(8'h00, 16'h1140, 4'h3);
		repeat (4) @(posedge clk);
		chk(16'({adv1000Full, adv1000Half, advAbility[7:5]}),
			16'({gigAdvFull, gigAdvHalf, eff}));
		wr(8'h3C, 16'hFFFF, 4'h3);
		chk(16'(resp), 16'(`RESP_SLVERR));
		rdreg(8'h3C);
		chk(16'(resp), 16'(`RESP_SLVERR));
		chk(rd, 16'h0000);
		complete_run;
	end
endmodule
